// *** rtl/rtxo_regs.svh ***
// Constants for the register transfer and exchange execution block.
// Assumes inclusion by bare name from the core and the bench.
`ifndef RTXO_REGS_SVH
`define RTXO_REGS_SVH
// ****************************************
// Opcodes
// ****************************************
`define RTXO_OP_COPY_X_TO_Z 16'h276C
`define RTXO_OP_READ_Y_BANK 16'h37AD
`define RTXO_OP_READ_Z_BANK 16'h37AE
`define RTXO_OP_LOAD_S_FROM_Y 16'h375E
`define RTXO_OP_LOAD_S_FROM_Z 16'h376E
`define RTXO_OP_COPY_Y_TO_X 16'h274D
`define RTXO_OP_COPY_Y_TO_Z 16'h276D
`define RTXO_OP_COPY_Z_TO_X 16'h274E
`define RTXO_OP_COPY_Z_TO_Y 16'h275E
`define RTXO_OP_HALT_IRQ 16'h27F3
`define RTXO_OP_SWAP_D_X 16'h37CC
`define RTXO_OP_SWAP_D_Y 16'h37DC
`define RTXO_OP_SWAP_D_Z 16'h37EC
`define RTXO_OP_SWAP_E_X 16'h374C
`define RTXO_OP_SWAP_E_Y 16'h375C
`define RTXO_OP_SWAP_E_Z 16'h376C
// ****************************************
// Cycle counts, stack offset, fields, reset values
// ****************************************
`define RTXO_CYC_XFER 4'h2
`define RTXO_CYC_WAIT 4'h8
`define RTXO_STACK_ADJ 20'h0_0002
`define RTXO_CCR_UPPER_MSB 15
`define RTXO_CCR_UPPER_LSB 4
`define RTXO_PK_MSB 3
`define RTXO_PK_LSB 0
`define RTXO_RST_WORD 16'h0000
`define RTXO_RST_BANK 4'h0
`define RTXO_RST_CCR 16'h0000
`endif

// *** rtl/rtxo_pkg.sv ***
// Types for the register transfer and exchange execution block.
// Assumes nothing beyond the constants header.
package rtxo_pkg;
	typedef enum logic [1:0] {
		RTXO_IDLE = 2'b00,
		RTXO_EXEC = 2'b01
	} rtxo_state_e;
	typedef enum logic [1:0] {
		RTXO_CC_NONE = 2'b00,
		RTXO_CC_UPPER = 2'b01,
		RTXO_CC_FULL = 2'b10,
		RTXO_CC_BANK = 2'b11
	} rtxo_cc_mode_e;
endpackage

// *** rtl/rtxo_core.sv ***
// Execute unit for inherent-mode transfer, exchange and wait instructions.
// Assumes the sequencer presents one opcode with op_valid while op_ready is
// high, and supplies condition results or stacked status on the cc inputs.
//
// Summary of operation
// - 276C copies X pair into Z pair, 2 cycles
// - 37AD puts Y bank in B low, zeros high
// - 37AE puts Z bank in B low, zeros high
// - 375E loads stack pair with Y pair minus 2
// - 376E loads stack pair with Z pair minus 2
// - 274D copies Y pair into X pair, 2 cycles
// - 276D copies Y pair into Z pair, 2 cycles
// - 274E copies Z pair into X pair, 2 cycles
// - 275E copies Z pair into Y pair, 2 cycles
// - 27F3 waits for interrupt, 8 cycles, flags kept
// - 37CC/37DC/37EC swap D with X/Y/Z
// - 374C/375C/376C swap E with X/Y/Z
// - Upper-flag update writes bits 15:4, bank kept
// - Full status restore writes all 16 bits
// - Bank-only restore writes bank field only
// - X bank and X register move together on copies; D/E swaps change the X register only
// - Stack bank and pointer load together
`timescale 1ns/1ps
`include "rtxo_regs.svh"
module rtxo_core import rtxo_pkg::*; #(
	parameter int CYC_W = 4
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic op_valid,
	input wire logic [15:0] op_code,
	output logic op_ready,
	output logic op_done,
	output logic op_illegal,
	output logic wait_active,
	input wire logic cc_write,
	input wire rtxo_cc_mode_e cc_mode,
	input wire logic [15:0] cc_value,
	output logic [15:0] acc_d,
	output logic [15:0] acc_e,
	output logic [15:0] index_reg_x,
	output logic [15:0] index_reg_y,
	output logic [15:0] index_reg_z,
	output logic [3:0] index_x_bank,
	output logic [3:0] index_y_bank,
	output logic [3:0] index_z_bank,
	output logic [15:0] stack_pointer,
	output logic [3:0] stack_bank,
	output logic [15:0] cond_code_reg
);
	// ****************************************
	// State
	// ****************************************
	rtxo_state_e state_reg, state_next;
	logic [CYC_W-1:0] cnt_reg, cnt_next;
	logic done_reg, done_next;
	logic ill_reg, ill_next;
	logic wait_reg, wait_next;
	logic [15:0] d_reg, d_next, e_reg, e_next;
	logic [15:0] x_reg, x_next, y_reg, y_next, z_reg, z_next, sp_reg, sp_next;
	logic [3:0] xk_reg, xk_next, yk_reg, yk_next, zk_reg, zk_next, sk_reg, sk_next;
	logic [15:0] ccr_reg, ccr_next;
	logic [19:0] stack_src;
	logic [19:0] stack_new;
	logic known;

	// ****************************************
	// Opcode legality
	// ****************************************
	// Kept apart from the updates so a foreign code never reaches a register
	always_comb begin
		known = 1'b0;
		case (op_code)
			`RTXO_OP_COPY_X_TO_Z,
			`RTXO_OP_READ_Y_BANK,
			`RTXO_OP_READ_Z_BANK,
			`RTXO_OP_LOAD_S_FROM_Y,
			`RTXO_OP_LOAD_S_FROM_Z,
			`RTXO_OP_COPY_Y_TO_X,
			`RTXO_OP_COPY_Y_TO_Z,
			`RTXO_OP_COPY_Z_TO_X,
			`RTXO_OP_COPY_Z_TO_Y,
			`RTXO_OP_HALT_IRQ,
			`RTXO_OP_SWAP_D_X,
			`RTXO_OP_SWAP_D_Y,
			`RTXO_OP_SWAP_D_Z,
			`RTXO_OP_SWAP_E_X,
			`RTXO_OP_SWAP_E_Y,
			`RTXO_OP_SWAP_E_Z: begin
				known = 1'b1;
			end
			default: begin
				known = 1'b0;
			end
		endcase
	end

	// ****************************************
	// Decode and next state
	// ****************************************
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		done_next = 1'b0;
		ill_next = 1'b0;
		wait_next = wait_reg;
		d_next = d_reg;
		e_next = e_reg;
		x_next = x_reg;
		y_next = y_reg;
		z_next = z_reg;
		sp_next = sp_reg;
		xk_next = xk_reg;
		yk_next = yk_reg;
		zk_next = zk_reg;
		sk_next = sk_reg;
		ccr_next = ccr_reg;
		stack_src = {yk_reg, y_reg};
		if (op_code == `RTXO_OP_LOAD_S_FROM_Z) begin
			stack_src = {zk_reg, z_reg};
		end
		// Borrow runs from pointer into bank as one 20-bit value
		stack_new = stack_src - `RTXO_STACK_ADJ;
		case (state_reg)
			RTXO_IDLE: begin
				if (op_valid) begin
					// Results commit at accept; the count only paces op_done
					cnt_next = CYC_W'(`RTXO_CYC_XFER - 4'h1);
					case (op_code)
						`RTXO_OP_COPY_X_TO_Z: begin
							{zk_next, z_next} = {xk_reg, x_reg};
						end
						`RTXO_OP_READ_Y_BANK: begin
							d_next[7:0] = {4'h0, yk_reg};
						end
						`RTXO_OP_READ_Z_BANK: begin
							d_next[7:0] = {4'h0, zk_reg};
						end
						`RTXO_OP_LOAD_S_FROM_Y, `RTXO_OP_LOAD_S_FROM_Z: begin
							{sk_next, sp_next} = stack_new;
						end
						`RTXO_OP_COPY_Y_TO_X: begin
							{xk_next, x_next} = {yk_reg, y_reg};
						end
						`RTXO_OP_COPY_Y_TO_Z: begin
							{zk_next, z_next} = {yk_reg, y_reg};
						end
						`RTXO_OP_COPY_Z_TO_X: begin
							{xk_next, x_next} = {zk_reg, z_reg};
						end
						`RTXO_OP_COPY_Z_TO_Y: begin
							// Destination taken as the Y bank, not the Z bank
							{yk_next, y_next} = {zk_reg, z_reg};
						end
						`RTXO_OP_HALT_IRQ: begin
							cnt_next = CYC_W'(`RTXO_CYC_WAIT - 4'h1);
							wait_next = 1'b1;
						end
						`RTXO_OP_SWAP_D_X: begin
							d_next = x_reg;
							x_next = d_reg;
						end
						`RTXO_OP_SWAP_D_Y: begin
							d_next = y_reg;
							y_next = d_reg;
						end
						`RTXO_OP_SWAP_D_Z: begin
							d_next = z_reg;
							z_next = d_reg;
						end
						`RTXO_OP_SWAP_E_X: begin
							e_next = x_reg;
							x_next = e_reg;
						end
						`RTXO_OP_SWAP_E_Y: begin
							e_next = y_reg;
							y_next = e_reg;
						end
						`RTXO_OP_SWAP_E_Z: begin
							e_next = z_reg;
							z_next = e_reg;
						end
						default: begin
							d_next = d_reg;
						end
					endcase
					if (known) begin
						state_next = RTXO_EXEC;
					end else begin
						// Foreign opcodes are answered at once and change nothing
						ill_next = 1'b1;
					end
				end
			end
			RTXO_EXEC: begin
				if (cnt_reg == CYC_W'(1)) begin
					state_next = RTXO_IDLE;
					done_next = 1'b1;
					wait_next = 1'b0;
				end
				cnt_next = cnt_reg - CYC_W'(1);
			end
			default: begin
				state_next = RTXO_IDLE;
			end
		endcase
		// Flags untouched by this group; only the sequencer's status path writes them
		if (cc_write) begin
			case (cc_mode)
				RTXO_CC_UPPER: begin
					ccr_next[`RTXO_CCR_UPPER_MSB:`RTXO_CCR_UPPER_LSB] =
						cc_value[`RTXO_CCR_UPPER_MSB:`RTXO_CCR_UPPER_LSB];
				end
				RTXO_CC_FULL: begin
					ccr_next = cc_value;
				end
				RTXO_CC_BANK: begin
					ccr_next[`RTXO_PK_MSB:`RTXO_PK_LSB] = cc_value[`RTXO_PK_MSB:`RTXO_PK_LSB];
				end
				default: begin
					ccr_next = ccr_reg;
				end
			endcase
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= RTXO_IDLE;
			cnt_reg <= '0;
			done_reg <= 1'b0;
			ill_reg <= 1'b0;
			wait_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			done_reg <= done_next;
			ill_reg <= ill_next;
			wait_reg <= wait_next;
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	always_ff @(posedge mclk) begin
		if (reset) begin
			d_reg <= `RTXO_RST_WORD;
			e_reg <= `RTXO_RST_WORD;
			x_reg <= `RTXO_RST_WORD;
			y_reg <= `RTXO_RST_WORD;
			z_reg <= `RTXO_RST_WORD;
			sp_reg <= `RTXO_RST_WORD;
			xk_reg <= `RTXO_RST_BANK;
			yk_reg <= `RTXO_RST_BANK;
			zk_reg <= `RTXO_RST_BANK;
			sk_reg <= `RTXO_RST_BANK;
		end else begin
			d_reg <= d_next;
			e_reg <= e_next;
			x_reg <= x_next;
			y_reg <= y_next;
			z_reg <= z_next;
			sp_reg <= sp_next;
			xk_reg <= xk_next;
			yk_reg <= yk_next;
			zk_reg <= zk_next;
			sk_reg <= sk_next;
		end
	end

	// ****************************************
	// Status register
	// ****************************************
	always_ff @(posedge mclk) begin
		if (reset) begin
			ccr_reg <= `RTXO_RST_CCR;
		end else begin
			ccr_reg <= ccr_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign op_ready = (state_reg == RTXO_IDLE);
	assign op_done = done_reg;
	assign op_illegal = ill_reg;
	assign wait_active = wait_reg;
	assign acc_d = d_reg;
	assign acc_e = e_reg;
	assign index_reg_x = x_reg;
	assign index_reg_y = y_reg;
	assign index_reg_z = z_reg;
	assign index_x_bank = xk_reg;
	assign index_y_bank = yk_reg;
	assign index_z_bank = zk_reg;
	assign stack_pointer = sp_reg;
	assign stack_bank = sk_reg;
	assign cond_code_reg = ccr_reg;
endmodule // rtxo_core

// *** dv/rtxo_properties.sv ***
// Concurrent checks on the execute unit ports.
// Assumes a bind onto rtxo_core; reset is synchronous, active high.
`timescale 1ns/1ps
module rtxo_properties import rtxo_pkg::*; (
	input wire logic mclk,
	input wire logic reset,
	input wire logic op_valid,
	input wire logic [15:0] op_code,
	input wire logic op_ready,
	input wire logic op_done,
	input wire logic op_illegal,
	input wire logic wait_active,
	input wire logic cc_write,
	input wire rtxo_cc_mode_e cc_mode,
	input wire logic [15:0] cc_value,
	input wire logic [15:0] acc_d,
	input wire logic [15:0] acc_e,
	input wire logic [15:0] index_reg_x,
	input wire logic [15:0] index_reg_y,
	input wire logic [15:0] index_reg_z,
	input wire logic [3:0] index_x_bank,
	input wire logic [3:0] index_y_bank,
	input wire logic [3:0] index_z_bank,
	input wire logic [15:0] stack_pointer,
	input wire logic [3:0] stack_bank,
	input wire logic [15:0] cond_code_reg
);
	// ****
	// Properties
	// ****
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence take_s;
		op_valid && op_ready;
	endsequence
	sequence hold_s;
		(wait_active && !op_done)[*7];
	endsequence
	a_xfer_two_cyc: assert property (take_s ##1 (!op_illegal && !wait_active) |-> ##1 op_done)
		else $error("transfer did not finish in two cycles");
	a_wait_eight_cyc: assert property (take_s ##1 wait_active |-> hold_s ##1 (op_done && !wait_active))
		else $error("wait did not finish in eight cycles");
	a_flags_kept: assert property (take_s and !cc_write |=> $stable(cond_code_reg))
		else $error("status changed by a transfer");
	a_stack_borrow: assert property (take_s and op_code == 16'h375E |=> {stack_bank, stack_pointer} == {$past(index_y_bank), $past(index_reg_y)} - 20'h0_0002)
		else $error("stack load from y pair wrong");
	a_copy_z_x: assert property (take_s and op_code == 16'h274E |=> {index_x_bank, index_reg_x} == {$past(index_z_bank), $past(index_reg_z)})
		else $error("z pair copy to x pair wrong");
	a_bank_to_b: assert property (take_s and op_code == 16'h37AE |=> acc_d[7:0] == {4'h0, $past(index_z_bank)} && $stable(acc_d[15:8]))
		else $error("z bank read into b wrong");
	a_swap_d_x: assert property (take_s and op_code == 16'h37CC |=> acc_d == $past(index_reg_x) && index_reg_x == $past(acc_d))
		else $error("d and x swap wrong");
	a_swap_e_z: assert property (take_s and op_code == 16'h376C |=> acc_e == $past(index_reg_z) && index_reg_z == $past(acc_e))
		else $error("e and z swap wrong");
	a_cc_upper: assert property (cc_write && cc_mode == RTXO_CC_UPPER |=> ((cond_code_reg ^ $past(cc_value)) & 16'hFFF0) == 16'h0000 && $stable(cond_code_reg[3:0]))
		else $error("upper status write wrong");
	a_cc_full: assert property (cc_write && cc_mode == RTXO_CC_FULL |=> cond_code_reg == $past(cc_value))
		else $error("full status write wrong");
	a_cc_bank: assert property (cc_write && cc_mode == RTXO_CC_BANK |=> cond_code_reg[3:0] == $past(cc_value[3:0]) && $stable(cond_code_reg[15:4]))
		else $error("bank status write wrong");
endmodule // rtxo_properties

// *** dv/reg_transfer_exchange_ops_test.sv ***
// Self-checking bench: reference model compared after every instruction.
// Assumes rtxo_core and rtxo_properties are compiled with it.
`timescale 1ns/1ps
`include "rtxo_regs.svh"
module reg_transfer_exchange_ops_test import rtxo_pkg::*; ;
	logic mclk = 0, reset = 1, op_valid = 0, cc_write = 0;
	logic op_ready, op_done, op_illegal, wait_active;
	logic [15:0] op_code = 0, cc_value = 0;
	rtxo_cc_mode_e cc_mode = RTXO_CC_NONE;
	logic [15:0] acc_d, acc_e, index_reg_x, index_reg_y, index_reg_z, stack_pointer, cond_code_reg;
	logic [3:0] index_x_bank, index_y_bank, index_z_bank, stack_bank;
	logic [19:0] mx, my, mz, ms, lat;
	logic [15:0] md, me, mc, t;
	int err_count = 0, checks_done = 0, cyc = 0, n, k;
	logic [15:0] ops [16] = '{16'h276C, 16'h37AD, 16'h37AE, 16'h375E, 16'h376E, 16'h274D,
		16'h276D, 16'h274E, 16'h275E, 16'h27F3, 16'h37CC, 16'h37DC, 16'h37EC,
		16'h374C, 16'h375C, 16'h376C};
	rtxo_core uut (.mclk(mclk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
		.op_ready(op_ready), .op_done(op_done), .op_illegal(op_illegal),
		.wait_active(wait_active), .cc_write(cc_write), .cc_mode(cc_mode),
		.cc_value(cc_value), .acc_d(acc_d), .acc_e(acc_e), .index_reg_x(index_reg_x),
		.index_reg_y(index_reg_y), .index_reg_z(index_reg_z), .index_x_bank(index_x_bank),
		.index_y_bank(index_y_bank), .index_z_bank(index_z_bank),
		.stack_pointer(stack_pointer), .stack_bank(stack_bank), .cond_code_reg(cond_code_reg));
	initial forever #25 mclk = ~mclk;
	task tally_and_finish;
		if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Timeout keeps a stuck handshake from hanging the run
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 6000) begin
			err_count++;
			tally_and_finish;
		end
	end
	task chk(input string s, input logic [19:0] e, input logic [19:0] g);
		checks_done++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", s, e, g);
			err_count++;
		end
	endtask
	task chk_all;
		chk("x pair", mx, {index_x_bank, index_reg_x});
		chk("y pair", my, {index_y_bank, index_reg_y});
		chk("z pair", mz, {index_z_bank, index_reg_z});
		chk("stack pair", ms, {stack_bank, stack_pointer});
		chk("acc d", {4'h0, md}, {4'h0, acc_d});
		chk("acc e", {4'h0, me}, {4'h0, acc_e});
		chk("status", {4'h0, mc}, {4'h0, cond_code_reg});
	endtask
	// Raises valid in the current cycle, so a call right after done is back to back
	task do_op(input logic [15:0] c);
		lat = 2;
		t = md;
		case (c)
			16'h276C: mz = mx;
			16'h37AD: md[7:0] = {4'h0, my[19:16]};
			16'h37AE: md[7:0] = {4'h0, mz[19:16]};
			16'h375E: ms = my - 20'h0_0002;
			16'h376E: ms = mz - 20'h0_0002;
			16'h274D: mx = my;
			16'h276D: mz = my;
			16'h274E: mx = mz;
			16'h275E: my = mz;
			16'h27F3: lat = 8;
			16'h37CC: {md, mx[15:0]} = {mx[15:0], t};
			16'h37DC: {md, my[15:0]} = {my[15:0], t};
			16'h37EC: {md, mz[15:0]} = {mz[15:0], t};
			16'h374C: {me, mx[15:0]} = {mx[15:0], me};
			16'h375C: {me, my[15:0]} = {my[15:0], me};
			16'h376C: {me, mz[15:0]} = {mz[15:0], me};
			default: lat = 1;
		endcase
		op_code = c;
		op_valid = 1;
		@(posedge mclk) #1 op_valid = 0;
		chk("ready", {19'h0, lat == 1}, {19'h0, op_ready});
		chk("wait flag", {19'h0, lat == 8}, {19'h0, wait_active});
		n = 1;
		while (op_done !== 1'b1 && op_illegal !== 1'b1 && n < 12) begin
			@(posedge mclk) #1;
			n++;
		end
		chk("latency", lat, 20'(n));
		chk("illegal", {19'h0, lat == 1}, {19'h0, op_illegal});
		chk("done", {19'h0, lat != 1}, {19'h0, op_done});
		chk_all;
	endtask
	task do_cc(input logic [1:0] m, input logic [15:0] v);
		cc_mode = rtxo_cc_mode_e'(m);
		cc_value = v;
		cc_write = 1;
		@(posedge mclk) #1 cc_write = 0;
		if (m == 2'h1) mc[15:4] = v[15:4];
		if (m == 2'h2) mc = v;
		if (m == 2'h3) mc[3:0] = v[3:0];
		chk("status write", {4'h0, mc}, {4'h0, cond_code_reg});
	endtask
	initial begin
		void'($urandom(50297));
		{mx, my, mz, ms, md, me, mc} = '0;
		repeat (2) @(posedge mclk);
		#1 reset = 0;
		chk("ready", 20'h1, {19'h0, op_ready});
		chk_all;
		foreach (ops[i]) do_op(ops[i]);
		repeat (150) begin
			if ($urandom % 3 == 0) do_cc(2'($urandom), 16'($urandom));
			k = $urandom % 20;
			do_op(k < 16 ? ops[k] : 16'($urandom));
		end
		reset = 1;
		@(posedge mclk) #1 reset = 0;
		{mx, my, mz, ms, md, me, mc} = '0;
		chk("ready", 20'h1, {19'h0, op_ready});
		chk_all;
		tally_and_finish;
	end
endmodule // reg_transfer_exchange_ops_test
bind rtxo_core rtxo_properties chk (.mclk(mclk), .reset(reset), .op_valid(op_valid),
	.op_code(op_code), .op_ready(op_ready), .op_done(op_done), .op_illegal(op_illegal),
	.wait_active(wait_active), .cc_write(cc_write), .cc_mode(cc_mode),
	.cc_value(cc_value), .acc_d(acc_d), .acc_e(acc_e), .index_reg_x(index_reg_x),
	.index_reg_y(index_reg_y), .index_reg_z(index_reg_z), .index_x_bank(index_x_bank),
	.index_y_bank(index_y_bank), .index_z_bank(index_z_bank),
	.stack_pointer(stack_pointer), .stack_bank(stack_bank), .cond_code_reg(cond_code_reg));
